/* File: hw/otpc_pkg.sv */
// package: constants for the otp program controller
package otpc_pkg;
  // commands
  localparam logic [7:0] CMD_OTP_SETUP = 8'hC0;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  // status bit positions
  localparam int SR_READY = 7;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_VOLT_ERR = 3;
  localparam int SR_PROTECT = 1;
  // otp address window
  localparam logic [23:0] OTP_ADDR_LO = 24'h000080;
  localparam logic [23:0] OTP_ADDR_HI = 24'h000088;
  // own register byte offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_ADDR = 4'h4;
  localparam logic [3:0] OFF_DATA = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'hC;
  // ctrl fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_CLR = 1;
  localparam int CTRL_RST = 2;
  // pin timing
  localparam int CLK_MHZ = 200;
  localparam int STROBE_NS = 70;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_PULSE_NS = 100;
  localparam int RESET_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOV_NS = 150;
  localparam int RECOV_CYC = (RECOV_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [9:0] {
    S_IDLE = 10'b0000000001,
    S_WR = 10'b0000000010,
    S_GAP = 10'b0000000100,
    S_RD = 10'b0000001000,
    S_CHK = 10'b0000010000,
    S_RST = 10'b0000100000,
    S_REC = 10'b0001000000,
    S_NEXT = 10'b0010000000,
    S_HOLD = 10'b0100000000,
    S_DONE = 10'b1000000000
  } otpc_state_t;
endpackage

/* File: hw/otpc_timer.sv */
// strobe and delay counter
`timescale 1ns/1ps
module otpc_timer (
  // clock
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic start,
  input wire logic [7:0] length,
  output logic done
);
  logic [7:0] cnt_reg;
  logic run_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 8'h00;
      run_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_reg <= length;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg <= 8'h01) begin
          run_reg <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
      end
    end
  end
endmodule

/* File: hw/otpc_ctrl.sv */
// host controller that programs the otp register of a parallel flash
// Contract
// - program starts with setup write C0h, then data write to location.
// - poll status by re-strobing output enable until ready bit is one.
// - after voltage error no further program until status is cleared.
// - after last program write read-array FFh.
// - on error clear status before any retry; code blocks retry only after a voltage error.
// - host reissues commands aborted by reset.
// - read-array command issued before array access after program.
// - chip select decoded, reset driven from system power good.
`timescale 1ns/1ps
module otpc_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // flash pins
  output logic [23:0] flash_addr,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_i,
  output logic chip_select_a,
  output logic write_enable_n,
  output logic output_enable_n,
  output logic reset_powerdown_n,
  input wire logic completion_status_pin,
  input wire logic system_power_good,
  // status
  output logic busy
);
  import otpc_pkg::*;
  otpc_state_t state_reg;
  logic [23:0] addr_reg;
  logic [7:0] data_reg;
  logic [7:0] status_reg;
  logic [7:0] wcmd_reg;
  logic [1:0] phase_reg;
  logic range_err_reg;
  logic done_reg;
  logic tstart;
  logic [7:0] tlen;
  logic tdone;
  logic aw_hold_reg, w_hold_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic voltage_block;
  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  assign wr_fire = aw_hold_reg && w_hold_reg && !s_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else begin
      s_awready <= !aw_hold_reg && !s_awready && s_awvalid;
      s_wready <= !w_hold_reg && !s_wready && s_wvalid;
      if (s_awvalid && s_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_wdata;
        w_strb_reg <= s_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= (busy && aw_addr_reg != OFF_STAT) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= RESP_OKAY;
    end else begin
      s_arready <= !s_arready && !s_rvalid && s_arvalid;
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp <= RESP_OKAY;
        unique case (s_araddr)
          OFF_CTRL: s_rdata <= {31'h0, busy};
          OFF_ADDR: s_rdata <= {8'h00, addr_reg};
          OFF_DATA: s_rdata <= {24'h000000, data_reg};
          OFF_STAT: s_rdata <= {22'h0, done_reg, range_err_reg, 
                                status_reg};
          default: begin
            s_rdata <= 32'h00000000;
            s_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // a latched voltage error blocks new programs until cleared
  assign voltage_block = status_reg[SR_VOLT_ERR];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
      addr_reg <= 24'h000000;
      data_reg <= 8'h00;
      status_reg <= 8'h00;
      wcmd_reg <= CMD_READ_ARRAY;
      phase_reg <= 2'b00;
      range_err_reg <= 1'b0;
      done_reg <= 1'b0;
      busy <= 1'b0;
      tstart <= 1'b0;
      tlen <= 8'h01;
    end else begin
      tstart <= 1'b0;
      tlen <= 8'(STROBE_CYC);
      if (!system_power_good && state_reg != S_RST) begin
        state_reg <= S_RST;
        status_reg <= 8'h00;
        busy <= 1'b1;
        tstart <= 1'b1;
        tlen <= 8'(RESET_CYC);
      end else begin
        unique case (state_reg)
          S_IDLE: begin
            if (wr_fire && aw_addr_reg == OFF_ADDR && w_strb_reg[0]) addr_reg <= w_data_reg[23:0];
            if (wr_fire && aw_addr_reg == OFF_DATA && w_strb_reg[0]) data_reg <= w_data_reg[7:0];
            if (wr_fire && aw_addr_reg == OFF_CTRL) begin
              done_reg <= 1'b0;
              if (w_data_reg[CTRL_RST]) begin
                state_reg <= S_RST;
                busy <= 1'b1;
                tstart <= 1'b1;
                tlen <= 8'(RESET_CYC);
              end else if (w_data_reg[CTRL_CLR]) begin
                wcmd_reg <= CMD_CLEAR_STATUS;
                phase_reg <= 2'b11;
                state_reg <= S_WR;
                busy <= 1'b1;
                tstart <= 1'b1;
              end else if (w_data_reg[CTRL_GO]) begin
                if (addr_reg < OTP_ADDR_LO || addr_reg >= OTP_ADDR_HI) begin
                  range_err_reg <= 1'b1;
                  done_reg <= 1'b1;
                end else if (!voltage_block) begin
                  range_err_reg <= 1'b0;
                  wcmd_reg <= CMD_OTP_SETUP;
                  phase_reg <= 2'b00;
                  state_reg <= S_WR;
                  busy <= 1'b1;
                  tstart <= 1'b1;
                end else begin
                  done_reg <= 1'b1;
                end
              end
            end
          end
          S_WR, S_HOLD: begin
            if (tdone) begin
              state_reg <= (state_reg == S_WR) ? S_GAP : S_RD;
              tstart <= 1'b1;
            end
          end
          S_GAP: begin
            if (tdone) begin
              unique case (phase_reg)
                2'b00: begin
                  wcmd_reg <= data_reg;
                  phase_reg <= 2'b01;
                  state_reg <= S_WR;
                  tstart <= 1'b1;
                end
                2'b01: begin
                  state_reg <= S_RD;
                  tstart <= 1'b1;
                end
                2'b10: begin
                  state_reg <= S_DONE;
                end
                default: begin
                  status_reg <= 8'h00;
                  wcmd_reg <= CMD_READ_ARRAY;
                  phase_reg <= 2'b10;
                  state_reg <= S_WR;
                  tstart <= 1'b1;
                end
              endcase
            end
          end
          S_RD: begin
            if (tdone) begin
              status_reg <= flash_dq_i;
              state_reg <= S_CHK;
            end
          end
          S_CHK: begin
            // output enable goes high then low again to refresh status
            if (status_reg[SR_READY]) begin
              wcmd_reg <= CMD_READ_ARRAY;
              phase_reg <= 2'b10;
              state_reg <= S_WR;
              tstart <= 1'b1;
            end else begin
              state_reg <= S_HOLD;
              tstart <= 1'b1;
            end
          end
          S_RST: begin
            if (tdone) begin
              state_reg <= S_REC;
              tstart <= 1'b1;
              tlen <= 8'(RECOV_CYC);
            end
          end
          S_REC: begin
            // aborted work shows as done with cleared status; software reissues it
            if (tdone && system_power_good) begin
              wcmd_reg <= CMD_READ_ARRAY;
              phase_reg <= 2'b10;
              state_reg <= S_WR;
              tstart <= 1'b1;
            end
          end
          S_DONE: begin
            busy <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_addr <= 24'h000000;
      flash_dq_o <= 8'h00;
      flash_dq_oe <= 1'b0;
      chip_select_a <= 1'b0;
      write_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      reset_powerdown_n <= 1'b0;
    end else begin
      reset_powerdown_n <= !(state_reg == S_RST);
      flash_addr <= addr_reg;
      flash_dq_o <= wcmd_reg;
      flash_dq_oe <= (state_reg == S_WR) || (state_reg == S_GAP && phase_reg != 2'b01);
      write_enable_n <= !(state_reg == S_WR);
      chip_select_a <= (state_reg == S_WR) || (state_reg == S_RD);
      output_enable_n <= !(state_reg == S_RD);
    end
  end
  otpc_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(tstart),
    .length(tlen),
    .done(tdone)
  );
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  we_needs_cs_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !write_enable_n |-> chip_select_a) else $error("write without select");
  setup_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(busy) && state_reg == S_WR && phase_reg == 2'b00 |-> wcmd_reg == CMD_OTP_SETUP)
    else $error("setup code missing");
  range_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(range_err_reg) |-> !busy) else $error("out of range started");
  volt_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_IDLE && voltage_block |=> !(state_reg == S_WR && phase_reg == 2'b00))
    else $error("program after voltage error");
  rst_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_RST |=> !reset_powerdown_n) else $error("reset pin not low");
  read_array_after_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_CHK && status_reg[SR_READY] |=> wcmd_reg == CMD_READ_ARRAY)
    else $error("no read array");
  sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_IDLE && !wr_fire && system_power_good |=> $stable(status_reg))
    else $error("status changed");
  rec_array_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == S_REC && tdone && system_power_good |=> wcmd_reg == CMD_READ_ARRAY)
    else $error("no read array after reset");
  prog_c: cover property (@(posedge aclk) state_reg == S_CHK && status_reg[SR_READY]);
  poll_c: cover property (@(posedge aclk) state_reg == S_HOLD);
  reset_c: cover property (@(posedge aclk) state_reg == S_REC);
endmodule

/* File: verif/otpc_flash_model.sv */
// behavioural parallel flash device with otp register for the controller bench
`timescale 1ns/1ps
module otpc_flash_model (
  // engine timing
  input wire logic aclk,
  // parallel pins
  input wire logic [23:0] flash_addr,
  input wire logic [7:0] flash_dq_o,
  input wire logic chip_select_a,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic reset_powerdown_n,
  output logic [7:0] flash_dq_i,
  output logic completion_status_pin
);
  import otpc_pkg::*;
  logic [7:0] sr = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] dq_d = 8'h00;
  logic [7:0] mem [0:7];
  logic [7:0] log_q[$];
  logic [23:0] addr_d = 24'h000000;
  logic we_d = 1'h1;
  logic cs_d = 1'h0;
  logic setup = 1'h0;
  logic stat_mode = 1'h0;
  logic program_enable_voltage_low = 1'h0;
  logic locked = 1'h0;
  logic drive;
  int busy_n = 0;
  int busy_len = 0;
  int rp_cnt = 0;
  int rp_len = 0;
  // --------------------------------
  // pins
  // --------------------------------
  assign drive = chip_select_a && !output_enable_n && reset_powerdown_n;
  // released bus shows the inverse of the last driven value
  assign flash_dq_i = drive ? (stat_mode ? {busy_n == 0, sr[6:0]} : 8'h5A) : ~last;
  // open drain with pull-up
  assign completion_status_pin = (busy_n > 0) ? 1'h0 : 1'h1;
  // --------------------------------
  // command latch and engine
  // --------------------------------
  always @(posedge aclk) begin
    we_d <= write_enable_n;
    cs_d <= chip_select_a;
    dq_d <= flash_dq_o;
    addr_d <= flash_addr;
    if (drive) last <= flash_dq_i;
    if (!reset_powerdown_n) begin
      sr <= 8'h00;
      busy_n <= 0;
      setup <= 1'h0;
      stat_mode <= 1'h0;
      rp_cnt <= rp_cnt + 1;
    end else begin
      if (rp_cnt > 0) rp_len <= rp_cnt;
      rp_cnt <= 0;
      if (busy_n > 0) busy_n <= busy_n - 1;
      if (write_enable_n && !we_d && cs_d) begin
        log_q.push_back(dq_d);
        if (setup) begin
          setup <= 1'h0;
          stat_mode <= 1'h1;
          if (!sr[3]) begin
            if (addr_d < OTP_ADDR_LO || addr_d >= OTP_ADDR_HI) sr <= sr | 8'h10;
            else if (program_enable_voltage_low) sr <= sr | 8'h0A;
            else if (locked) sr <= sr | 8'h12;
            else begin
              mem[addr_d[2:0]] <= dq_d;
              busy_n <= busy_len;
            end
          end
        end else begin
          case (dq_d)
            CMD_OTP_SETUP: setup <= 1'h1;
            CMD_CLEAR_STATUS: sr <= 8'h00;
            CMD_READ_STATUS: stat_mode <= 1'h1;
            CMD_READ_ARRAY: stat_mode <= 1'h0;
            default: setup <= 1'h0;
          endcase
        end
      end
    end
  end
endmodule

/* File: verif/otpc_ctrl_tb.sv */
// self-checking bench for the otp program controller
`timescale 1ns/1ps
module otpc_ctrl_tb;
  import otpc_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic pgood = 1'h1;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, dq_oe, cs_a, we_n, oe_n, rp_n, sts, busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] faddr;
  logic [7:0] dq_o, dq_i;
  logic [7:0] exp_sr = 8'h00;
  logic [7:0] exp_stat = 8'h00;
  logic [7:0] exq[$];
  int num_errors = 0;
  int n_tests = 0;
  always #2.5 aclk = ~aclk;
  otpc_ctrl otpc_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
    .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
    .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .flash_addr(faddr), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i),
    .chip_select_a(cs_a), .write_enable_n(we_n), .output_enable_n(oe_n),
    .reset_powerdown_n(rp_n), .completion_status_pin(sts), .system_power_good(pgood),
    .busy(busy));
  otpc_flash_model dev (.aclk(aclk), .flash_addr(faddr), .flash_dq_o(dq_o),
    .chip_select_a(cs_a), .write_enable_n(we_n), .output_enable_n(oe_n),
    .reset_powerdown_n(rp_n), .flash_dq_i(dq_i), .completion_status_pin(sts));
  // --------------------------------
  // bus tasks and compares
  // --------------------------------
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    @(posedge aclk);
    ta = 1'h0;
    tw = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awready && !ta) awvalid <= 1'h0;
      if (wready && !tw) wvalid <= 1'h0;
      ta = ta | awready;
      tw = tw | wready;
    end
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // while either strobe is low, data pins drive only if it is the write strobe
  always @(negedge aclk) begin
    if (aresetn && !(we_n && oe_n)) chk("data drive", !we_n, dq_oe);
  end
  task automatic chk_log();
    chk("command count", exq.size(), dev.log_q.size());
    foreach (exq[i]) chk("command byte", exq[i], dev.log_q[i]);
  endtask
  task automatic wait_idle();
    repeat (3) @(posedge aclk);
    while (busy) @(posedge aclk);
  endtask
  // program one location and predict the outcome
  task automatic go(input logic [23:0] a, input logic [7:0] d);
    logic [1:0] r;
    logic [31:0] v;
    logic prog;
    axw(OFF_ADDR, {8'h00, a}, r);
    axw(OFF_DATA, {24'h000000, d}, r);
    dev.log_q.delete();
    exq.delete();
    prog = !exp_sr[3] && !dev.program_enable_voltage_low && !dev.locked;
    if (!exp_sr[3]) begin
      exq = '{CMD_OTP_SETUP, d, CMD_READ_ARRAY};
      if (dev.program_enable_voltage_low) exp_sr = exp_sr | 8'h0A;
      else if (dev.locked) exp_sr = exp_sr | 8'h12;
      exp_stat = 8'h80 | exp_sr;
    end
    axw(OFF_CTRL, 32'h00000001, r);
    chk("go response", RESP_OKAY, r);
    wait_idle();
    chk_log();
    axr(OFF_STAT, v, r);
    chk("status copy", {2'h2, exp_stat}, v[9:0]);
    if (prog) chk("otp byte", d, dev.mem[a[2:0]]);
  endtask
  task automatic clr();
    logic [1:0] r;
    dev.log_q.delete();
    exq = '{CMD_CLEAR_STATUS, CMD_READ_ARRAY};
    exp_sr = 8'h00;
    axw(OFF_CTRL, 32'h00000002, r);
    wait_idle();
    chk_log();
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    end_of_test();
  end
  // --------------------------------
  // scenarios
  // --------------------------------
  initial begin
    logic [1:0] r;
    logic [31:0] v;
    void'($urandom(32'hD68A));
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    axr(4'h2, v, r);
    chk("unmapped read", RESP_SLVERR, r);
    for (int i = 0; i < 3; i++) go(OTP_ADDR_LO + 24'($urandom_range(0, 7)), 8'($urandom()));
    go(OTP_ADDR_HI - 24'h000001, 8'($urandom()));
    dev.busy_len = 300;
    fork
      go(OTP_ADDR_LO, 8'h3C);
      begin
        repeat (100) @(posedge aclk);
        chk("busy flag", 1'h1, busy);
        chk("completion pin", 1'h0, sts);
        axw(OFF_DATA, 32'h0, r);
        chk("write while busy", RESP_SLVERR, r);
      end
    join
    dev.busy_len = 0;
    dev.program_enable_voltage_low = 1'h1;
    go(OTP_ADDR_LO + 24'h000001, 8'hA5);
    dev.program_enable_voltage_low = 1'h0;
    go(OTP_ADDR_LO + 24'h000002, 8'h5A);
    clr();
    dev.locked = 1'h1;
    go(OTP_ADDR_LO + 24'h000003, 8'h11);
    dev.locked = 1'h0;
    go(OTP_ADDR_LO + 24'h000004, 8'h22);
    clr();
    dev.busy_len = 300;
    axw(OFF_CTRL, 32'h00000001, r);
    repeat (120) @(posedge aclk);
    pgood <= 1'h0;
    repeat (5) @(posedge aclk);
    chk("reset pin", 1'h0, rp_n);
    pgood <= 1'h1;
    wait_idle();
    chk("reset pulse", 1'h1, dev.rp_len >= RESET_CYC);
    axr(OFF_STAT, v, r);
    chk("cleared copy", 8'h00, v[7:0]);
    dev.busy_len = 0;
    dev.rp_len = 0;
    exp_sr = 8'h00;
    axw(OFF_CTRL, 32'h00000004, r);
    wait_idle();
    chk("reset pulse", 1'h1, dev.rp_len >= RESET_CYC);
    go(OTP_ADDR_LO + 24'h000005, 8'h77);
    for (int i = 0; i < 2; i++) begin
      v = i ? {8'h00, OTP_ADDR_HI} : {8'h00, OTP_ADDR_LO - 24'h000001};
      axw(OFF_ADDR, v, r);
      dev.log_q.delete();
      axw(OFF_CTRL, 32'h00000001, r);
      wait_idle();
      chk("range commands", 0, dev.log_q.size());
      axr(OFF_STAT, v, r);
      chk("range flag", 1'h1, v[8]);
    end
    end_of_test();
  end
endmodule
